// ### src/alert_pkg.sv
// Constants, register map and types for the status and alert block.
package alert_pkg;

  // ****************************************************************
  // Register map (byte addresses on the plain register port)
  // ****************************************************************
  localparam logic [7:0] ADDR_STATUS   = 8'h01;
  localparam logic [7:0] ADDR_MASK     = 8'h03;
  localparam logic [7:0] ADDR_GPIO     = 8'h0B;
  localparam logic [7:0] ADDR_CTRL     = 8'h0C;
  localparam logic [7:0] ADDR_DEGLITCH = 8'h0D;
  localparam logic [7:0] ADDR_IDLE     = 8'h0E;
  localparam logic [7:0] ADDR_CLEAR    = 8'h0F;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int ST_BUS        = 0;
  localparam int ST_IDLE       = 1;
  localparam int ST_SLEEP      = 2;
  localparam int ST_EXT_LSB    = 3;
  localparam int NUM_EXT       = 5;
  localparam int NUM_STATUS    = 8;
  localparam int MASK_PIN_EN   = 8;
  localparam int CTRL_DRV_EN   = 0;
  localparam int CTRL_DIR      = 1;
  localparam int CTRL_SMOKE    = 2;
  localparam logic [1:0] GPIO_FUNC_ALERT = 2'h2;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [8:0] MASK_RST     = 9'h000;
  localparam logic [1:0] GPIO_RST     = 2'h0;
  localparam logic [2:0] CTRL_RST     = 3'h0;
  localparam logic [4:0] DEGLITCH_RST = 5'h00;
  localparam logic [9:0] IDLE_RST     = 10'h001;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CORE_CLK_MHZ    = 200;
  localparam int DEGLITCH_MAX_MS = 20;
  // 32.768 ticks per millisecond, rounded up so the filter never
  // runs short of the programmed time.
  localparam logic [5:0] TICKS_PER_MS = 6'h21;
  localparam int IDLE_UNIT_US    = 100;
  localparam int IDLE_UNIT_CYCLES = IDLE_UNIT_US * CORE_CLK_MHZ;
  localparam logic [9:0] IDLE_MIN_UNITS = 10'h001;
  localparam logic [9:0] IDLE_MAX_UNITS = 10'h3E8;
  localparam logic [9:0] DG_CNT_MAX     = 10'h3FF;

  // Role of the host alert pin.
  typedef enum logic [2:0] {
    MODE_ALERT  = 3'b001,
    MODE_MIRROR = 3'b010,
    MODE_INPUT  = 3'b100
  } pin_mode_t;

endpackage

// ### src/deglitch_if.sv
// Interface between the alert block and its deglitch filter.
`timescale 1ns/1ps
interface deglitch_if;
  logic       tick;
  logic       sample;
  logic [9:0] limit;
  logic       level;
  logic [9:0] count;

  modport filt (input tick, input sample, input limit,
                output level, output count);
  modport ctl  (output tick, output sample, output limit,
                input level, input count);
endinterface

// ### src/bus_deglitch.sv
// Digital deglitch filter for the synchronised bus comparator.
`timescale 1ns/1ps
module bus_deglitch
(
  input  wire logic core_clk,
  input  wire logic reset_n,
  deglitch_if.filt  dg
);

  logic [9:0] cnt_q;
  logic       level_q;

  // ****************************************************************
  // Run of high samples, counted in 32 kHz ticks
  // ****************************************************************
  // A low sample restarts the run, so a burst of noise never adds up.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_q   <= 10'h000;
      level_q <= 1'b0;
    end
    else if (dg.tick)
    begin
      if (!dg.sample)
      begin
        cnt_q   <= 10'h000;
        level_q <= 1'b0;
      end
      else
      begin
        if (cnt_q != alert_pkg::DG_CNT_MAX)
          cnt_q <= cnt_q + 10'h001;
        // One spare bit keeps the saturated count from wrapping to zero.
        level_q <= ({1'b0, cnt_q} + 11'h001)
                   >= {1'b0, dg.limit};
      end
    end
  end

  assign dg.level = level_q;
  assign dg.count = cnt_q;

  AST_DG_LOW_RESETS: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    dg.tick && !dg.sample |=> cnt_q == 10'h000 && !level_q)
    else $error("Deglitch did not restart on a low sample.");

  AST_DG_NO_EARLY: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    $rose(level_q) |-> {1'b0, $past(cnt_q)} + 11'h001
      >= {1'b0, $past(dg.limit)} && $past(dg.sample))
    else $error("Deglitch output rose before the programmed time.");

endmodule

// ### src/alert_top.sv
// Status latch, alert routing and bus receiver of the alarm front end.
`timescale 1ns/1ps

// Summary of operation
// - Bus comparator synchronised to 32 kHz first.
// - Deglitch length programmable from 0 to 20 ms.
// - Deglitched bus seen on alert pin, status.
// - Deglitched bus high latches the bus flag.
// - Bus driven high during smoke, low after.
// - Status bits latch when their condition occurs.
// - Mask bit lets each status bit alert.
// - Alert on general pin only when function 0x2.
// - Alert on host pin only when enabled.
// - Status read clears only vanished conditions.
// - Bus driver enabled disconnects alert output.
// - Driver on, direction 0: pin mirrors bus.
// - Driver on, direction 1: pin steers driver.
// - Boost idle time compared to programmed threshold.
// - Sleep timer expiry latches sleep done flag.
module alert_top
#(
  parameter int IDLE_UNIT_CYCLES = alert_pkg::IDLE_UNIT_CYCLES
)
(
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        clk32k_in,
  input  wire logic        bus_comp_in,
  input  wire logic        boost_sw_in,
  input  wire logic [4:0]  cond_in,
  input  wire logic        sleep_done_in,
  input  wire logic        host_alert_i,
  output logic             host_alert_o,
  output logic             host_alert_oe,
  output logic             gpio_o,
  output logic             gpio_oe,
  output logic             bus_drive_o,
  output logic             bus_drive_oe,
  output logic             irq
);

  localparam int NS = alert_pkg::NUM_STATUS;

  // ****************************************************************
  // Decoding shared by the pin logic and its checks
  // ****************************************************************
  function automatic alert_pkg::pin_mode_t pin_mode
    (input logic drv_en, input logic dir);
    if (!drv_en)
      pin_mode = alert_pkg::MODE_ALERT;
    else if (!dir)
      pin_mode = alert_pkg::MODE_MIRROR;
    else
      pin_mode = alert_pkg::MODE_INPUT;
  endfunction

  logic [NS-1:0] status_q;
  logic [NS-1:0] cond;
  logic [8:0]    mask_q;
  logic [1:0]    gpio_func_q;
  logic [2:0]    ctrl_q;
  logic [4:0]    dg_ms_q;
  logic [9:0]    idle_thr_q;
  logic [15:0]   rdata_q;
  logic          rd_status;
  logic          clr_wr;
  logic [NS-1:0] clr_bits;
  logic          alert_any;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Every pin but sleep_done_in passes two flops; only the second stage is read.
  logic [8:0] pin_s1_q;
  logic [8:0] pin_s2_q;
  logic       clk32_d_q;
  logic       bsw_d_q;
  logic [8:0] pin_raw;

  assign pin_raw = {host_alert_i, cond_in, boost_sw_in, bus_comp_in,
                    clk32k_in};

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_s1_q  <= 9'h000;
      pin_s2_q  <= 9'h000;
      clk32_d_q <= 1'b0;
      bsw_d_q   <= 1'b0;
    end
    else
    begin
      pin_s1_q  <= pin_raw;
      pin_s2_q  <= pin_s1_q;
      clk32_d_q <= pin_s2_q[0];
      bsw_d_q   <= pin_s2_q[2];
    end
  end

  // ****************************************************************
  // Bus receiver: 32 kHz sampling and deglitch
  // ****************************************************************
  logic tick32;
  logic comp32_q;
  logic tick_d_q;

  assign tick32 = pin_s2_q[0] && !clk32_d_q;

  // Comparator is resampled on the 32 kHz edge before filtering.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      comp32_q <= 1'b0;
      tick_d_q <= 1'b0;
    end
    else
    begin
      tick_d_q <= tick32;
      if (tick32)
        comp32_q <= pin_s2_q[1];
    end
  end

  deglitch_if dgi ();
  assign dgi.tick   = tick_d_q;
  assign dgi.sample = comp32_q;
  assign dgi.limit  = 10'(dg_ms_q * alert_pkg::TICKS_PER_MS);

  bus_deglitch u_dg
  (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .dg       (dgi)
  );

  // ****************************************************************
  // Boost idle timer
  // ****************************************************************
  // Prescaler in 100 us units; the toggle of the switch node restarts.
  logic [15:0] pre_q;
  logic [9:0]  idle_q;
  logic        bsw_edge;

  assign bsw_edge = pin_s2_q[2] ^ bsw_d_q;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pre_q  <= 16'h0000;
      idle_q <= 10'h000;
    end
    else if (bsw_edge)
    begin
      pre_q  <= 16'h0000;
      idle_q <= 10'h000;
    end
    else if (pre_q == 16'(IDLE_UNIT_CYCLES - 1))
    begin
      pre_q <= 16'h0000;
      if (idle_q != alert_pkg::IDLE_MAX_UNITS)
        idle_q <= idle_q + 10'h001;
    end
    else
      pre_q <= pre_q + 16'h0001;
  end

  // ****************************************************************
  // Status conditions and sticky bits
  // ****************************************************************
  assign cond[alert_pkg::ST_BUS]   = dgi.level;
  assign cond[alert_pkg::ST_IDLE]  = idle_q >= idle_thr_q;
  assign cond[alert_pkg::ST_SLEEP] = sleep_done_in;
  assign cond[NS-1:alert_pkg::ST_EXT_LSB] = pin_s2_q[7:3];

  assign rd_status = reg_rd && reg_addr == alert_pkg::ADDR_STATUS;
  assign clr_wr    = reg_wr && reg_addr == alert_pkg::ADDR_CLEAR;
  assign clr_bits  = clr_wr ? reg_wdata[NS-1:0] : {NS{1'b0}};

  // A live condition wins over a read or a clear in the same cycle.
  genvar gi;
  generate
    for (gi = 0; gi < NS; gi++)
    begin : g_status
      always_ff @(posedge core_clk or negedge reset_n)
      begin
        if (!reset_n)
          status_q[gi] <= 1'b0;
        else if (cond[gi])
          status_q[gi] <= 1'b1;
        else if (rd_status || clr_bits[gi])
          status_q[gi] <= 1'b0;
      end
    end
  endgenerate

  // ****************************************************************
  // Register writes
  // ****************************************************************
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mask_q      <= alert_pkg::MASK_RST;
      gpio_func_q <= alert_pkg::GPIO_RST;
      ctrl_q      <= alert_pkg::CTRL_RST;
      dg_ms_q     <= alert_pkg::DEGLITCH_RST;
      idle_thr_q  <= alert_pkg::IDLE_RST;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        alert_pkg::ADDR_MASK:     mask_q      <= reg_wdata[8:0];
        alert_pkg::ADDR_GPIO:     gpio_func_q <= reg_wdata[1:0];
        alert_pkg::ADDR_CTRL:     ctrl_q      <= reg_wdata[2:0];
        alert_pkg::ADDR_DEGLITCH:
          // Settings beyond the longest filter time are clamped.
          if (reg_wdata[4:0] > 5'(alert_pkg::DEGLITCH_MAX_MS))
            dg_ms_q <= 5'(alert_pkg::DEGLITCH_MAX_MS);
          else
            dg_ms_q <= reg_wdata[4:0];
        alert_pkg::ADDR_IDLE:
          if (reg_wdata[9:0] < alert_pkg::IDLE_MIN_UNITS)
            idle_thr_q <= alert_pkg::IDLE_MIN_UNITS;
          else if (reg_wdata[9:0] > alert_pkg::IDLE_MAX_UNITS)
            idle_thr_q <= alert_pkg::IDLE_MAX_UNITS;
          else
            idle_thr_q <= reg_wdata[9:0];
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Register reads: data stand only in the cycle after the strobe
  // ****************************************************************
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      rdata_q <= 16'h0000;
    else if (!reg_rd)
      rdata_q <= 16'h0000;
    else
    begin
      case (reg_addr)
        alert_pkg::ADDR_STATUS:   rdata_q <= {8'h00, status_q};
        alert_pkg::ADDR_MASK:     rdata_q <= {7'h00, mask_q};
        alert_pkg::ADDR_GPIO:     rdata_q <= {14'h0000, gpio_func_q};
        alert_pkg::ADDR_CTRL:     rdata_q <= {13'h0000, ctrl_q};
        alert_pkg::ADDR_DEGLITCH: rdata_q <= {11'h000, dg_ms_q};
        alert_pkg::ADDR_IDLE:     rdata_q <= {6'h00, idle_thr_q};
        default:                  rdata_q <= 16'h0000;
      endcase
    end
  end

  assign reg_rdata = rdata_q;

  // ****************************************************************
  // Alert routing and pin drivers
  // ****************************************************************
  alert_pkg::pin_mode_t mode;
  logic host_o_q;
  logic host_oe_q;
  logic gpio_q;
  logic gpio_oe_q;
  logic bus_q;
  logic irq_q;

  assign alert_any = |(status_q & mask_q[NS-1:0]);
  assign mode = pin_mode(ctrl_q[alert_pkg::CTRL_DRV_EN],
                         ctrl_q[alert_pkg::CTRL_DIR]);

  // Host pin role follows the bus driver settings.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      host_o_q  <= 1'b0;
      host_oe_q <= 1'b0;
    end
    else
    begin
      case (mode)
        alert_pkg::MODE_ALERT:
        begin
          host_oe_q <= 1'b1;
          host_o_q  <= dgi.level ||
            (alert_any && mask_q[alert_pkg::MASK_PIN_EN]);
        end
        alert_pkg::MODE_MIRROR:
        begin
          host_oe_q <= 1'b1;
          host_o_q  <= dgi.level;
        end
        default:
        begin
          host_oe_q <= 1'b0;
          host_o_q  <= 1'b0;
        end
      endcase
    end
  end

  // General pin, level interrupt and bus driver.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      gpio_q    <= 1'b0;
      gpio_oe_q <= 1'b0;
      bus_q     <= 1'b0;
      irq_q     <= 1'b0;
    end
    else
    begin
      gpio_oe_q <= gpio_func_q == alert_pkg::GPIO_FUNC_ALERT;
      gpio_q    <= alert_any &&
                   gpio_func_q == alert_pkg::GPIO_FUNC_ALERT;
      irq_q     <= alert_any;
      // Smoke comes from software, or from the host pin as input.
      if (mode == alert_pkg::MODE_INPUT)
        bus_q <= pin_s2_q[8];
      else
        bus_q <= ctrl_q[alert_pkg::CTRL_SMOKE];
    end
  end

  assign host_alert_o  = host_o_q;
  assign host_alert_oe = host_oe_q;
  assign gpio_o        = gpio_q;
  assign gpio_oe       = gpio_oe_q;
  assign bus_drive_o   = bus_q;
  assign bus_drive_oe  = ctrl_q[alert_pkg::CTRL_DRV_EN];
  assign irq           = irq_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  AST_SAMPLE_ON_TICK: assert property (
    !tick32 |=> comp32_q == $past(comp32_q))
    else $error("Comparator sample moved without a 32 kHz tick.");

  AST_BUS_LATCH: assert property (
    dgi.level |=> status_q[alert_pkg::ST_BUS])
    else $error("Bus flag not latched after filter output.");

  AST_STICKY: assert property (
    !rd_status && !clr_wr |=> (status_q & $past(status_q))
      == $past(status_q))
    else $error("Status bit dropped without read or clear.");

  AST_READ_KEEPS_LIVE: assert property (
    rd_status && cond[alert_pkg::ST_IDLE]
      |=> status_q[alert_pkg::ST_IDLE])
    else $error("Read cleared a bit whose condition persists.");

  AST_IRQ_FOLLOWS: assert property (
    ##1 irq == $past(|(status_q & mask_q[NS-1:0])))
    else $error("Interrupt does not match masked status.");

  AST_GPIO_GATE: assert property (
    gpio_oe |-> $past(gpio_func_q) == alert_pkg::GPIO_FUNC_ALERT)
    else $error("General pin driven without alert function.");

  AST_HOST_ENABLE: assert property (
    mode == alert_pkg::MODE_ALERT && !dgi.level
      && !mask_q[alert_pkg::MASK_PIN_EN] |=> !host_alert_o)
    else $error("Host pin alerted with pin enable clear.");

  AST_HOST_DISCONNECT: assert property (
    mode == alert_pkg::MODE_INPUT |=> !host_alert_oe)
    else $error("Host pin driven while used as input.");

  AST_HOST_MIRROR: assert property (
    mode == alert_pkg::MODE_MIRROR |=> host_alert_o == $past(dgi.level))
    else $error("Host pin does not mirror the bus.");

  AST_BUS_FROM_HOST: assert property (
    mode == alert_pkg::MODE_INPUT |=> bus_drive_o == $past(pin_s2_q[8]))
    else $error("Bus driver not steered by host pin.");

  AST_BUS_SMOKE: assert property (
    mode != alert_pkg::MODE_INPUT
      |=> bus_drive_o == $past(ctrl_q[alert_pkg::CTRL_SMOKE]))
    else $error("Bus driver does not follow smoke state.");

  AST_IDLE_FLAG: assert property (
    idle_q >= idle_thr_q |=> status_q[alert_pkg::ST_IDLE])
    else $error("Idle flag not set at threshold.");

  AST_SLEEP_FLAG: assert property (
    sleep_done_in |=> status_q[alert_pkg::ST_SLEEP])
    else $error("Sleep done flag not latched.");

endmodule

// ### verification/mcu_model.sv
// Behavioural host microcontroller at the far side of the alert pin.
`timescale 1ns/1ps
module mcu_model
(
  input  wire logic core_clk,
  input  wire logic host_alert_o,
  input  wire logic host_alert_oe,
  input  wire logic drive_en,
  input  wire logic drive_level,
  output logic      host_alert_i
);
  // ****************************************************************
  // Pin resolution
  // ****************************************************************
  logic last_q = 1'b0;

  // The pin has no pull, so a released pin shows the inverse of its
  // last level instead of a value the simulator would settle on.
  always_comb
  begin
    if (host_alert_oe)
      host_alert_i = host_alert_o;
    else if (drive_en)
      host_alert_i = drive_level;
    else
      host_alert_i = ~last_q;
  end

  // Remember the last level seen on the pin.
  always_ff @(posedge core_clk)
  begin
    last_q <= host_alert_i;
  end
endmodule

// ### verification/status_alert_and_alarm_bus_receiver_bench.sv
// Self-checking bench for the status latch and alert routing block.
`timescale 1ns/1ps
module status_alert_and_alarm_bus_receiver_bench;
  // ****************************************************************
  // Stimulus and harness
  // ****************************************************************
  logic        core_clk      = 1'b0;
  logic        reset_n       = 1'b0;
  logic [7:0]  reg_addr      = 8'h00;
  logic [15:0] reg_wdata     = 16'h0000;
  logic        reg_wr        = 1'b0;
  logic        reg_rd        = 1'b0;
  logic [15:0] reg_rdata;
  logic        clk32k_in     = 1'b0;
  logic        bus_comp_in   = 1'b0;
  logic        boost_sw_in   = 1'b0;
  logic [4:0]  cond_in       = 5'h00;
  logic        sleep_done_in = 1'b0;
  logic        host_alert_i;
  logic        host_alert_o;
  logic        host_alert_oe;
  logic        gpio_o;
  logic        gpio_oe;
  logic        bus_drive_o;
  logic        bus_drive_oe;
  logic        irq;
  logic        drive_en      = 1'b0;
  logic        drive_level   = 1'b0;
  logic        boost_run     = 1'b1;
  logic [6:0]  slow_cnt      = 7'h00;
  int          fail_count    = 0;
  int          total_checks  = 0;

  alert_top #(.IDLE_UNIT_CYCLES(4)) DUT (.core_clk(core_clk),
    .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .clk32k_in(clk32k_in), .bus_comp_in(bus_comp_in),
    .boost_sw_in(boost_sw_in), .cond_in(cond_in),
    .sleep_done_in(sleep_done_in), .host_alert_i(host_alert_i),
    .host_alert_o(host_alert_o), .host_alert_oe(host_alert_oe),
    .gpio_o(gpio_o), .gpio_oe(gpio_oe), .bus_drive_o(bus_drive_o),
    .bus_drive_oe(bus_drive_oe), .irq(irq));

  mcu_model host (.core_clk(core_clk), .host_alert_o(host_alert_o),
    .host_alert_oe(host_alert_oe), .drive_en(drive_en),
    .drive_level(drive_level), .host_alert_i(host_alert_i));

  // Core clock at 200 MHz.
  initial
  begin
    forever #2.5 core_clk = ~core_clk;
  end

  // Slow clock sped up to 80 core cycles so a 1 ms filter fits the run.
  always @(posedge core_clk)
  begin
    slow_cnt <= (slow_cnt == 7'h4F) ? 7'h00 : slow_cnt + 7'h01;
    clk32k_in <= (slow_cnt < 7'h28);
  end

  // Boost switch toggles every cycle unless a test lets it go idle.
  always @(posedge core_clk)
  begin
    if (boost_run)
      boost_sw_in <= ~boost_sw_in;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_bit(input string what, input logic exp,
                           input logic got);
    check(what, {15'h0, exp}, {15'h0, got});
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic read_check(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] d;
    reg_read(a, d);
    check("register", e, d);
  endtask

  task automatic pulse_sleep();
    @(posedge core_clk);
    sleep_done_in <= 1'b1;
    @(posedge core_clk);
    sleep_done_in <= 1'b0;
    tick(3);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic test_reset();
    check_bit("irq", 1'b0, irq);
    // The host pin is driven from the first edge after release, as it
    // carries the filter level in its alert role.
    check_bit("pin oe", 1'b1, host_alert_oe);
    check_bit("gpio oe", 1'b0, gpio_oe);
    check_bit("bus oe", 1'b0, bus_drive_oe);
    read_check(alert_pkg::ADDR_MASK, {7'h0, alert_pkg::MASK_RST});
    read_check(alert_pkg::ADDR_IDLE, {6'h0, alert_pkg::IDLE_RST});
    read_check(alert_pkg::ADDR_CTRL, {13'h0, alert_pkg::CTRL_RST});
    read_check(alert_pkg::ADDR_STATUS, 16'h0000);
    reg_write(8'h20, 16'hFFFF);
    read_check(8'h20, 16'h0000);
    reg_write(alert_pkg::ADDR_GPIO, 16'h0003);
    read_check(alert_pkg::ADDR_GPIO, 16'h0003);
    tick(1);
    check("rdata after", 16'h0000, reg_rdata);
    $display("reset test done");
  endtask

  task automatic test_sleep();
    reg_write(alert_pkg::ADDR_GPIO, 16'h0000);
    reg_write(alert_pkg::ADDR_MASK, 16'h0104);
    @(posedge core_clk);
    sleep_done_in <= 1'b1;
    @(posedge core_clk);
    sleep_done_in <= 1'b0;
    #1 check_bit("irq early", 1'b0, irq);
    tick(1);
    check_bit("irq", 1'b1, irq);
    check_bit("pin", 1'b1, host_alert_o);
    tick(5);
    check_bit("irq held", 1'b1, irq);
    read_check(alert_pkg::ADDR_STATUS, 16'h0004);
    tick(2);
    check_bit("irq cleared", 1'b0, irq);
    reg_write(alert_pkg::ADDR_MASK, 16'h0100);
    pulse_sleep();
    check_bit("pin masked", 1'b0, host_alert_o);
    read_check(alert_pkg::ADDR_STATUS, 16'h0004);
    reg_write(alert_pkg::ADDR_MASK, 16'h0004);
    pulse_sleep();
    check_bit("pin off", 1'b0, host_alert_o);
    check_bit("irq on", 1'b1, irq);
    read_check(alert_pkg::ADDR_STATUS, 16'h0004);
    $display("sleep test done");
  endtask

  task automatic test_cond();
    reg_write(alert_pkg::ADDR_MASK, 16'h0008);
    @(posedge core_clk);
    cond_in <= 5'h11;
    tick(6);
    check_bit("irq", 1'b1, irq);
    read_check(alert_pkg::ADDR_STATUS, 16'h0088);
    reg_write(alert_pkg::ADDR_CLEAR, 16'h00FF);
    read_check(alert_pkg::ADDR_STATUS, 16'h0088);
    for (int f = 0; f < 4; f++)
    begin
      reg_write(alert_pkg::ADDR_GPIO, 16'(f));
      tick(2);
      check_bit("gpio oe", f == 2, gpio_oe);
      check_bit("gpio", f == 2, gpio_o);
    end
    reg_write(alert_pkg::ADDR_GPIO, 16'h0002);
    @(posedge core_clk);
    cond_in <= 5'h00;
    tick(4);
    check_bit("gpio live", 1'b1, gpio_o);
    reg_write(alert_pkg::ADDR_CLEAR, 16'h0008);
    read_check(alert_pkg::ADDR_STATUS, 16'h0080);
    tick(2);
    check_bit("gpio idle", 1'b0, gpio_o);
    reg_write(alert_pkg::ADDR_GPIO, 16'h0000);
    $display("condition test done");
  endtask

  task automatic test_pin();
    reg_write(alert_pkg::ADDR_MASK, 16'h0104);
    pulse_sleep();
    reg_write(alert_pkg::ADDR_CTRL, 16'h0001);
    tick(2);
    check_bit("pin", 1'b0, host_alert_o);
    check_bit("bus oe", 1'b1, bus_drive_oe);
    reg_write(alert_pkg::ADDR_CTRL, 16'h0005);
    tick(2);
    check_bit("bus smoke", 1'b1, bus_drive_o);
    reg_write(alert_pkg::ADDR_CTRL, 16'h0001);
    tick(2);
    check_bit("bus clear", 1'b0, bus_drive_o);
    reg_write(alert_pkg::ADDR_CTRL, 16'h0003);
    tick(2);
    check_bit("pin oe", 1'b0, host_alert_oe);
    for (int v = 1; v >= 0; v--)
    begin
      @(posedge core_clk);
      drive_en <= 1'b1;
      drive_level <= v[0];
      tick(5);
      check_bit("bus steer", v[0], bus_drive_o);
    end
    drive_en <= 1'b0;
    reg_write(alert_pkg::ADDR_CTRL, 16'h0000);
    read_check(alert_pkg::ADDR_STATUS, 16'h0004);
    $display("pin role test done");
  endtask

  task automatic test_bus();
    reg_write(alert_pkg::ADDR_MASK, 16'h0000);
    reg_write(alert_pkg::ADDR_DEGLITCH, 16'h0001);
    @(posedge core_clk);
    bus_comp_in <= 1'b1;
    tick(20 * 80);
    bus_comp_in <= 1'b0;
    tick(2 * 80);
    bus_comp_in <= 1'b1;
    tick(30 * 80);
    read_check(alert_pkg::ADDR_STATUS, 16'h0000);
    tick(6 * 80);
    check_bit("pin bus", 1'b1, host_alert_o);
    reg_write(alert_pkg::ADDR_CTRL, 16'h0001);
    tick(2);
    check_bit("pin mirror", 1'b1, host_alert_o);
    reg_write(alert_pkg::ADDR_CTRL, 16'h0000);
    bus_comp_in <= 1'b0;
    tick(3 * 80);
    check_bit("pin low", 1'b0, host_alert_o);
    read_check(alert_pkg::ADDR_STATUS, 16'h0001);
    read_check(alert_pkg::ADDR_STATUS, 16'h0000);
    reg_write(alert_pkg::ADDR_DEGLITCH, 16'h0000);
    bus_comp_in <= 1'b1;
    tick(2 * 80 + 4);
    read_check(alert_pkg::ADDR_STATUS, 16'h0001);
    bus_comp_in <= 1'b0;
    tick(2 * 80);
    read_check(alert_pkg::ADDR_STATUS, 16'h0001);
    $display("bus receiver test done");
  endtask

  task automatic test_idle();
    reg_write(alert_pkg::ADDR_IDLE, 16'h0002);
    reg_write(alert_pkg::ADDR_MASK, 16'h0002);
    read_check(alert_pkg::ADDR_STATUS, 16'h0000);
    boost_run <= 1'b0;
    tick(2);
    read_check(alert_pkg::ADDR_STATUS, 16'h0000);
    tick(30);
    check_bit("irq idle", 1'b1, irq);
    read_check(alert_pkg::ADDR_STATUS, 16'h0002);
    boost_run <= 1'b1;
    tick(6);
    read_check(alert_pkg::ADDR_STATUS, 16'h0002);
    read_check(alert_pkg::ADDR_STATUS, 16'h0000);
    $display("idle timer test done");
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Reset for 20 cycles, then run every scenario in turn.
  initial
  begin
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    tick(1);
    test_reset();
    test_sleep();
    test_cond();
    test_pin();
    test_bus();
    test_idle();
    give_verdict();
  end

  // The scenarios need about 5400 cycles; a hang ends the run.
  initial
  begin
    repeat (40000) @(posedge core_clk);
    fail_count++;
    give_verdict();
  end
endmodule
